// ---- rtl/edfa_top.sv ----
// Directional earth fault alarm: pick-up logic, event and record generation, APB registers.
// How it works
// R1: Alarm on/off make time-stamped events, maskable.
// R2: Twelve newest operation records are kept.
// R3: Records carry current ratio and operating angle.
// R4: Eight setting groups, switched while running.
// R5: Time stamps count whole milliseconds.
// R6: Alarm event counter, cleared by software.
// R7: Residual current source: coarse, sensitive, computed.
// R8: Front end delivers new values every 5 ms.
// R9: Voltage source: measured or computed channel.
// R10: Records keep 20 ms pre-fault average.
// R11: Angle judged only above both squelch limits.
// R12: Alarm needs zero sequence voltage present.
// R13: Pick-up needs current, voltage and sector.
// R14: Release below 97 percent of threshold.
// R15: Current threshold in 0.001 steps, default 1.200.
// R16: Voltage threshold in 0.01 percent, default 20.
// R17: Earthing type codes one to four.
// R18: Multi-criteria check only in broad mode.
// R19: Broad mode uses its own thresholds.
// R20: Earthed sector half-width, default 88 degrees.
// R21: Earthed sector centre, default zero.
// R22: Angle blinder for earthed and broad modes.
// R23: Unearthed forward means current lags 90 degrees.
// R24: Compensated forward means current opposes voltage.
// R25: Broad mode divider splits overlap, default 45.
// R26: Each new measurement re-evaluates with current group.
`timescale 1ns/1ps
module edfa_top #(
	parameter int unsigned MS_CYCLES = edfa_pkg::MS_CYCLES
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire edfa_pkg::edfa_meas_t meas,
	input wire logic meas_valid,
	input wire logic [2:0] setting_group,
	input wire logic [2:0] fault_phases,
	input wire logic sym_fault,
	output logic alarm,
	output logic event_valid,
	output edfa_pkg::edfa_event_t event_data
);

	////////////////////////////////////////////////////////////////////////////
	// Storage.
	logic [15:0] grp_reg [edfa_pkg::NUM_GRP][edfa_pkg::NUM_FLD];
	edfa_pkg::edfa_rec_t log_reg [edfa_pkg::LOG_DEPTH];
	logic [2:0] ctrl_reg;
	logic [15:0] count_reg;
	logic [31:0] ms_time_reg;
	logic [31:0] ms_div_reg;
	logic [3:0] log_sel_reg;
	logic [3:0] log_wp_reg;
	logic [3:0] log_cnt_reg;
	logic alarm_reg;
	logic [15:0] max_cur_reg;
	edfa_pkg::edfa_rec_t pend_reg;
	logic [31:0] num_reg;
	logic [15:0] den_reg;
	edfa_pkg::edfa_state_t state_reg;
	edfa_pkg::edfa_state_t state_next;
	logic div_start_reg;
	logic event_valid_reg;
	edfa_pkg::edfa_event_t event_reg;
	logic [31:0] prdata_reg;
	logic pslverr_reg;

	////////////////////////////////////////////////////////////////////////////
	// Active setting group, read live so a change applies at the next evaluation.
	logic [15:0] act [edfa_pkg::NUM_FLD];
	edfa_pkg::edfa_mode_t mode;
	edfa_pkg::edfa_div_t divw;
	wire broad;
	wire [15:0] i_thr;
	wire [15:0] u_thr;
	wire [11:0] div_eff;

	assign act = grp_reg[setting_group]; // R4 R26
	assign mode = edfa_pkg::edfa_mode_t'(act[edfa_pkg::F_MODE]); // R17
	assign divw = edfa_pkg::edfa_div_t'(act[edfa_pkg::F_DIV]);
	assign broad = mode.etype == edfa_pkg::ET_BROAD;
	assign i_thr = broad ? act[edfa_pkg::F_BR_I_THR] : act[edfa_pkg::F_I_THR]; // R15 R19
	assign u_thr = broad ? act[edfa_pkg::F_BR_U_THR] : act[edfa_pkg::F_U_THR]; // R16 R19
	assign div_eff = divw.en ? divw.val : 12'h000; // R25

	////////////////////////////////////////////////////////////////////////////
	// Input selection.
	wire [15:0] cur;
	wire [15:0] volt;
	wire [15:0] pre_avg;

	assign cur = (mode.isrc == edfa_pkg::SRC_COARSE) ? meas.cur_coarse : // R7
		(mode.isrc == edfa_pkg::SRC_SENS) ? meas.cur_sens : meas.cur_calc;
	assign volt = mode.usrc ? meas.u0_calc : meas.u0_meas; // R9

	edfa_avg u_avg (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.sample_valid(meas_valid),
		.sample(cur),
		.avg(pre_avg)
	); // R10

	////////////////////////////////////////////////////////////////////////////
	// Angle check. The angle is that of the current relative to the voltage.
	wire [11:0] phi;
	wire squelch_ok;
	wire in_une;
	wire in_comp;
	wire in_earth;
	wire signed [15:0] phi_signed;
	wire signed [15:0] blind;
	wire blind_ok;
	logic sector_ok;
	wire ang_ok;
	wire comp_class;

	assign phi = meas.angle;
	assign squelch_ok = (cur > edfa_pkg::I0_SQUELCH) && (volt > edfa_pkg::U0_SQUELCH); // R11
	assign in_une = edfa_pkg::ang_in(phi, edfa_pkg::UNE_CENTER, edfa_pkg::CLASS_HALF); // R23
	assign in_comp = edfa_pkg::ang_in(phi, edfa_pkg::COMP_CENTER, edfa_pkg::CLASS_HALF); // R24
	assign in_earth = edfa_pkg::ang_in(phi, act[edfa_pkg::F_CENTER][11:0], act[edfa_pkg::F_HALF][11:0]); // R20 R21
	assign phi_signed = ({1'b0, phi} >= edfa_pkg::ANG_HALF) ?
		16'(signed'({3'b000, phi}) - signed'({3'b000, edfa_pkg::ANG_FULL})) : signed'({4'h0, phi});
	assign blind = signed'(act[edfa_pkg::F_BLIND]);
	assign blind_ok = phi_signed >= (blind - edfa_pkg::BLIND_SPAN); // R22

	always_comb begin
		unique case (mode.etype)
			edfa_pkg::ET_UNE: sector_ok = in_une;
			edfa_pkg::ET_COMP: sector_ok = in_comp;
			edfa_pkg::ET_EARTH: sector_ok = in_earth && blind_ok;
			edfa_pkg::ET_BROAD: sector_ok = (in_une || in_comp) && blind_ok;
			default: sector_ok = 1'b0;
		endcase
	end

	assign ang_ok = squelch_ok && sector_ok; // R11 R13
	assign comp_class = broad && (phi < edfa_pkg::COMP_CENTER + div_eff); // R25

	////////////////////////////////////////////////////////////////////////////
	// Threshold comparators with the built-in reset ratio.
	wire mc_ok;
	wire pick_cond;
	wire rel_cond;
	wire rise;
	wire fall;
	wire [15:0] max_cur_upd;

	assign mc_ok = !(broad && (mode.mc == edfa_pkg::MC_ON)) || sym_fault; // R18
	assign pick_cond = (cur > i_thr) && (volt > u_thr) && ang_ok && mc_ok; // R12 R13
	assign rel_cond = (24'(cur) * edfa_pkg::PCT_FULL < 24'(i_thr) * edfa_pkg::RESET_PCT) || // R14
		(24'(volt) * edfa_pkg::PCT_FULL < 24'(u_thr) * edfa_pkg::RESET_PCT);
	assign rise = meas_valid && !alarm_reg && pick_cond; // R26
	assign fall = meas_valid && alarm_reg && rel_cond; // R26
	assign max_cur_upd = (cur > max_cur_reg) ? cur : max_cur_reg;

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			alarm_reg <= 1'b0;
			max_cur_reg <= 16'h0000;
		end else begin
			if (rise || fall) begin
				alarm_reg <= rise;
			end
			if (rise) begin
				max_cur_reg <= cur;
			end else if (meas_valid && alarm_reg) begin
				max_cur_reg <= max_cur_upd;
			end
		end
	end

	assign alarm = alarm_reg;

	////////////////////////////////////////////////////////////////////////////
	// Millisecond time base.
	wire ms_tick;

	assign ms_tick = ms_div_reg == MS_CYCLES - 1;

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			ms_div_reg <= 32'h00000000;
			ms_time_reg <= 32'h00000000;
		end else begin
			ms_div_reg <= ms_tick ? 32'h00000000 : ms_div_reg + 32'h00000001;
			if (ms_tick) begin
				ms_time_reg <= ms_time_reg + 32'h00000001; // R5
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Record capture: latch at the transition, divide for the ratio, then store.
	wire [15:0] ratio;
	wire div_done;
	wire capture;
	edfa_pkg::edfa_rec_t pend_next;

	assign capture = (rise || fall) && (state_reg == edfa_pkg::ST_IDLE);

	always_comb begin
		pend_next = pend_reg;
		if (capture) begin
			pend_next.stamp = ms_time_reg; // R5
			pend_next.on = rise;
			pend_next.grp = setting_group; // R2
			pend_next.comp = comp_class;
			pend_next.ftype = fault_phases;
			pend_next.u0 = volt;
			pend_next.angle = phi; // R3
			pend_next.pre = pre_avg; // R10
		end
		if (div_done) begin
			pend_next.ratio = ratio; // R3
		end
	end

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			edfa_pkg::ST_IDLE: if (capture) state_next = edfa_pkg::ST_DIV;
			edfa_pkg::ST_DIV: if (div_done) state_next = edfa_pkg::ST_REC;
			edfa_pkg::ST_REC: state_next = edfa_pkg::ST_IDLE;
			default: state_next = edfa_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= edfa_pkg::ST_IDLE;
			pend_reg <= '0;
			num_reg <= 32'h00000000;
			den_reg <= 16'h0000;
			div_start_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			pend_reg <= pend_next;
			div_start_reg <= capture;
			if (capture) begin
				num_reg <= 32'(rise ? cur : max_cur_upd) * edfa_pkg::RATIO_SCALE;
				den_reg <= i_thr;
			end
		end
	end

	edfa_div u_div (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.start(div_start_reg),
		.num(num_reg),
		.den(den_reg),
		.done(div_done),
		.quo(ratio)
	);

	////////////////////////////////////////////////////////////////////////////
	// Record ring and event output.
	wire rec_write;
	wire evt_enabled;

	assign rec_write = state_reg == edfa_pkg::ST_REC;
	assign evt_enabled = pend_reg.on ? ctrl_reg[0] : ctrl_reg[1]; // R1

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < edfa_pkg::LOG_DEPTH; i++) begin
				log_reg[i] <= '0;
			end
			log_wp_reg <= 4'h0;
			log_cnt_reg <= 4'h0;
		end else if (rec_write) begin
			log_reg[log_wp_reg] <= pend_reg; // R2
			log_wp_reg <= (log_wp_reg == edfa_pkg::LOG_LAST) ? 4'h0 : log_wp_reg + 4'h1; // R2
			if (log_cnt_reg <= edfa_pkg::LOG_LAST) begin
				log_cnt_reg <= log_cnt_reg + 4'h1;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			event_valid_reg <= 1'b0;
			event_reg <= '0;
		end else begin
			event_valid_reg <= rec_write && evt_enabled; // R1
			if (rec_write && evt_enabled) begin
				event_reg <= '{on: pend_reg.on, stamp: pend_reg.stamp}; // R1
			end
		end
	end

	assign event_valid = event_valid_reg;
	assign event_data = event_reg;

	////////////////////////////////////////////////////////////////////////////
	// APB decode. Read data is latched in the setup cycle; the access never waits.
	wire setup;
	wire wr;
	wire grp_hit;
	wire [2:0] grp_idx;
	wire [3:0] fld_idx;
	wire [4:0] slot_sum;
	wire [3:0] slot;
	wire cnt_clear;
	edfa_pkg::edfa_rec_t rec_sel;
	logic [31:0] rd_data;
	logic rd_hit;

	assign setup = psel && !penable;
	assign wr = psel && penable && pwrite;
	assign grp_idx = paddr[8:6];
	assign fld_idx = paddr[5:2];
	assign grp_hit = (paddr[11:9] == edfa_pkg::A_GRP_PAGE) && (fld_idx < edfa_pkg::NUM_FLD) &&
		(paddr[1:0] == 2'b00);
	assign slot_sum = 5'(log_wp_reg) + 5'(edfa_pkg::LOG_LAST) - 5'(log_sel_reg);
	assign slot = (slot_sum > 5'(edfa_pkg::LOG_LAST)) ? 4'(slot_sum - 5'(edfa_pkg::LOG_DEPTH)) : slot_sum[3:0];
	assign rec_sel = log_reg[slot];
	assign cnt_clear = wr && (paddr == edfa_pkg::A_CTRL) && pwdata[2];

	always_comb begin
		rd_hit = 1'b1;
		rd_data = 32'h00000000;
		unique case (paddr)
			edfa_pkg::A_CTRL: rd_data = {30'h00000000, ctrl_reg[1:0]};
			edfa_pkg::A_STATUS: rd_data = {23'h000000, comp_class, 1'b0, setting_group, 2'b00,
				ang_ok, alarm_reg};
			edfa_pkg::A_COUNT: rd_data = {16'h0000, count_reg};
			edfa_pkg::A_TIME: rd_data = ms_time_reg;
			edfa_pkg::A_LOG_SEL: rd_data = {28'h0000000, log_sel_reg};
			edfa_pkg::A_LOG_CNT: rd_data = {24'h000000, log_wp_reg, log_cnt_reg};
			edfa_pkg::A_LOG_TIME: rd_data = rec_sel.stamp;
			edfa_pkg::A_LOG_INFO: rd_data = {23'h000000, rec_sel.on, rec_sel.grp, rec_sel.comp,
				1'b0, rec_sel.ftype};
			edfa_pkg::A_LOG_RATIO: rd_data = {16'h0000, rec_sel.ratio};
			edfa_pkg::A_LOG_U0: rd_data = {16'h0000, rec_sel.u0};
			edfa_pkg::A_LOG_ANGLE: rd_data = {20'h00000, rec_sel.angle};
			edfa_pkg::A_LOG_PRE: rd_data = {16'h0000, rec_sel.pre};
			default: begin
				rd_hit = grp_hit;
				rd_data = grp_hit ? {16'h0000, grp_reg[grp_idx][fld_idx]} : 32'h00000000;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			prdata_reg <= 32'h00000000;
			pslverr_reg <= 1'b0;
		end else if (setup) begin
			prdata_reg <= pwrite ? 32'h00000000 : rd_data;
			pslverr_reg <= !rd_hit;
		end
	end

	assign prdata = prdata_reg;
	assign pready = 1'b1;
	assign pslverr = pslverr_reg;

	////////////////////////////////////////////////////////////////////////////
	// Register writes.
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_reg <= edfa_pkg::CTRL_RESET;
			log_sel_reg <= 4'h0;
			for (int g = 0; g < edfa_pkg::NUM_GRP; g++) begin
				for (int f = 0; f < edfa_pkg::NUM_FLD; f++) begin
					grp_reg[g][f] <= edfa_pkg::GRP_DEFAULT[f]; // R15 R16 R17 R20 R21 R22 R25
				end
			end
		end else if (wr) begin
			if (paddr == edfa_pkg::A_CTRL) begin
				ctrl_reg <= {1'b0, pwdata[1:0]}; // R1
			end
			if (paddr == edfa_pkg::A_LOG_SEL) begin
				log_sel_reg <= pwdata[3:0];
			end
			if (grp_hit) begin
				grp_reg[grp_idx][fld_idx] <= pwdata[15:0] & edfa_pkg::GRP_WMASK[fld_idx]; // R4
			end
		end
	end

	// A new alarm in the clearing cycle counts as the first after the clear.
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			count_reg <= 16'h0000;
		end else if (cnt_clear) begin
			count_reg <= rise ? 16'h0001 : 16'h0000; // R6
		end else if (rise) begin
			count_reg <= count_reg + 16'h0001; // R6
		end
	end

endmodule : edfa_top

// ---- rtl/edfa_pkg.sv ----
// Shared constants, layouts and types of the directional earth fault alarm block.
package edfa_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Timing.
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned TSTAMP_RES_NS = 1_000_000;
	localparam int unsigned MS_CYCLES = TSTAMP_RES_NS / CLK_PERIOD_NS;
	localparam int unsigned MEAS_PERIOD_MS = 5;
	localparam int unsigned PREFAULT_WIN_MS = 20;
	localparam int unsigned AVG_DEPTH = PREFAULT_WIN_MS / MEAS_PERIOD_MS;
	localparam int unsigned AVG_SHIFT = $clog2(AVG_DEPTH);

	////////////////////////////////////////////////////////////////////////////
	// Measurement scaling: currents in 0.001 x nominal, voltages in 0.01 % of nominal, angles in 0.1 degree.
	localparam logic [15:0] I0_SQUELCH = 16'h000A;
	localparam logic [15:0] U0_SQUELCH = 16'h0064;
	localparam logic [23:0] RESET_PCT = 24'h000061;
	localparam logic [23:0] PCT_FULL = 24'h000064;
	localparam logic [31:0] RATIO_SCALE = 32'h000003E8;
	localparam logic [12:0] ANG_FULL = 13'h0E10;
	localparam logic [12:0] ANG_HALF = 13'h0708;
	localparam logic [11:0] UNE_CENTER = 12'hA8C;
	localparam logic [11:0] COMP_CENTER = 12'h708;
	localparam logic [11:0] CLASS_HALF = 12'h370;
	localparam logic signed [15:0] BLIND_SPAN = 16'sh0384;

	////////////////////////////////////////////////////////////////////////////
	// Setting codes.
	localparam logic [2:0] ET_UNE = 3'h1;
	localparam logic [2:0] ET_COMP = 3'h2;
	localparam logic [2:0] ET_EARTH = 3'h3;
	localparam logic [2:0] ET_BROAD = 3'h4;
	localparam logic [1:0] MC_ON = 2'h2;
	localparam logic [1:0] SRC_COARSE = 2'h0;
	localparam logic [1:0] SRC_SENS = 2'h1;

	////////////////////////////////////////////////////////////////////////////
	// Register map, byte addresses.
	localparam logic [11:0] A_CTRL = 12'h000;
	localparam logic [11:0] A_STATUS = 12'h004;
	localparam logic [11:0] A_COUNT = 12'h008;
	localparam logic [11:0] A_TIME = 12'h00C;
	localparam logic [11:0] A_LOG_SEL = 12'h010;
	localparam logic [11:0] A_LOG_CNT = 12'h014;
	localparam logic [11:0] A_LOG_TIME = 12'h018;
	localparam logic [11:0] A_LOG_INFO = 12'h01C;
	localparam logic [11:0] A_LOG_RATIO = 12'h020;
	localparam logic [11:0] A_LOG_U0 = 12'h024;
	localparam logic [11:0] A_LOG_ANGLE = 12'h028;
	localparam logic [11:0] A_LOG_PRE = 12'h02C;
	localparam logic [2:0] A_GRP_PAGE = 3'h1;
	localparam logic [2:0] CTRL_RESET = 3'h3;
	localparam int unsigned NUM_GRP = 8;
	localparam int unsigned NUM_FLD = 9;
	localparam int unsigned LOG_DEPTH = 12;
	localparam logic [3:0] LOG_LAST = 4'hB;

	// Field index inside a setting group page.
	localparam logic [3:0] F_I_THR = 4'h0;
	localparam logic [3:0] F_U_THR = 4'h1;
	localparam logic [3:0] F_MODE = 4'h2;
	localparam logic [3:0] F_BR_I_THR = 4'h3;
	localparam logic [3:0] F_BR_U_THR = 4'h4;
	localparam logic [3:0] F_HALF = 4'h5;
	localparam logic [3:0] F_CENTER = 4'h6;
	localparam logic [3:0] F_BLIND = 4'h7;
	localparam logic [3:0] F_DIV = 4'h8;

	localparam logic [15:0] GRP_DEFAULT [NUM_FLD] = '{16'h04B0, 16'h07D0, 16'h0011, 16'h04B0,
		16'h07D0, 16'h0370, 16'h0000, 16'hFC7C, 16'h81C2};
	localparam logic [15:0] GRP_WMASK [NUM_FLD] = '{16'hFFFF, 16'hFFFF, 16'h1337, 16'hFFFF,
		16'hFFFF, 16'h0FFF, 16'h0FFF, 16'hFFFF, 16'h8FFF};

	////////////////////////////////////////////////////////////////////////////
	// Types.
	typedef struct packed {
		logic [2:0] rsv_a;
		logic usrc;
		logic [1:0] rsv_b;
		logic [1:0] isrc;
		logic [1:0] rsv_c;
		logic [1:0] mc;
		logic rsv_d;
		logic [2:0] etype;
	} edfa_mode_t;

	typedef struct packed {
		logic en;
		logic [2:0] rsv;
		logic [11:0] val;
	} edfa_div_t;

	typedef struct packed {
		logic [15:0] cur_coarse;
		logic [15:0] cur_sens;
		logic [15:0] cur_calc;
		logic [15:0] u0_meas;
		logic [15:0] u0_calc;
		logic [11:0] angle;
	} edfa_meas_t;

	typedef struct packed {
		logic [31:0] stamp;
		logic on;
		logic [2:0] grp;
		logic comp;
		logic [2:0] ftype;
		logic [15:0] ratio;
		logic [15:0] u0;
		logic [11:0] angle;
		logic [15:0] pre;
	} edfa_rec_t;

	typedef struct packed {
		logic on;
		logic [31:0] stamp;
	} edfa_event_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_DIV = 2'b01,
		ST_REC = 2'b11
	} edfa_state_t;

	// True when phi lies within +/- half of ctr on the circle.
	function automatic logic ang_in(input logic [11:0] phi, input logic [11:0] ctr, input logic [11:0] half);
		logic [12:0] d;
		logic [11:0] m;
		d = {1'b0, phi} + ANG_FULL - {1'b0, ctr};
		if (d >= ANG_FULL) begin
			d = d - ANG_FULL;
		end
		m = (d > ANG_HALF) ? 12'(ANG_FULL - d) : d[11:0];
		return m <= half;
	endfunction : ang_in

endpackage : edfa_pkg

// ---- rtl/edfa_avg.sv ----
// Running average of the last measurement samples, for pre-fault data.
`timescale 1ns/1ps
module edfa_avg (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic sample_valid,
	input wire logic [15:0] sample,
	output logic [15:0] avg
);

	logic [15:0] tap_reg [edfa_pkg::AVG_DEPTH];
	logic [17:0] sum_reg;

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			tap_reg[0] <= 16'h0000;
		end else if (sample_valid) begin
			tap_reg[0] <= sample;
		end
	end

	// The oldest tap leaves the sum as the newest sample enters it.
	for (genvar i = 1; i < edfa_pkg::AVG_DEPTH; i++) begin : g_tap
		always_ff @(posedge sys_clk or negedge rst_b) begin
			if (!rst_b) begin
				tap_reg[i] <= 16'h0000;
			end else if (sample_valid) begin
				tap_reg[i] <= tap_reg[i-1];
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			sum_reg <= 18'h00000;
		end else if (sample_valid) begin
			sum_reg <= sum_reg + 18'(sample) - 18'(tap_reg[edfa_pkg::AVG_DEPTH-1]);
		end
	end

	assign avg = 16'(sum_reg >> edfa_pkg::AVG_SHIFT);

endmodule : edfa_avg

// ---- rtl/edfa_div.sv ----
// Serial restoring divider with a saturating 16-bit quotient.
`timescale 1ns/1ps
module edfa_div (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic start,
	input wire logic [31:0] num,
	input wire logic [15:0] den,
	output logic done,
	output logic [15:0] quo
);

	logic [5:0] cnt_reg;
	logic done_reg;
	logic [16:0] rem_reg;
	logic [31:0] q_reg;
	logic [16:0] shifted;
	logic fits;

	assign shifted = {rem_reg[15:0], q_reg[31]};
	assign fits = shifted >= {1'b0, den};

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_reg <= 6'h00;
			rem_reg <= 17'h00000;
			q_reg <= 32'h00000000;
		end else if (start) begin
			cnt_reg <= 6'h20;
			rem_reg <= 17'h00000;
			q_reg <= num;
		end else if (cnt_reg != 6'h00) begin
			cnt_reg <= cnt_reg - 6'h01;
			rem_reg <= fits ? shifted - {1'b0, den} : shifted;
			q_reg <= {q_reg[30:0], fits};
		end
	end

	// Done follows the edge that lands the last quotient bit.
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			done_reg <= 1'b0;
		end else begin
			done_reg <= cnt_reg == 6'h01;
		end
	end

	assign done = done_reg;
	// A zero divisor yields all ones and so saturates too.
	assign quo = (q_reg[31:16] != 16'h0000) ? 16'hFFFF : q_reg[15:0];

endmodule : edfa_div

// ---- verification/edfa_front.sv ----
// Measurement front end model: a fresh sample set once per update period.
`timescale 1ns/1ps
module edfa_front #(
	parameter int unsigned PERIOD = 60
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire edfa_pkg::edfa_meas_t sample_in,
	output edfa_pkg::edfa_meas_t meas,
	output logic meas_valid
);
	int unsigned cnt;
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt <= 0;
			meas <= '0;
			meas_valid <= 1'b0;
		end else begin
			cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
			meas_valid <= (cnt == PERIOD - 1);
			if (cnt == PERIOD - 1) begin
				meas <= sample_in;
			end
		end
	end
endmodule : edfa_front

// ---- verification/edfa_top_chk.sv ----
// Port checker of the alarm block.
`timescale 1ns/1ps
module edfa_top_chk (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pslverr,
	input wire edfa_pkg::edfa_meas_t meas,
	input wire logic meas_valid,
	input wire logic alarm,
	input wire logic event_valid,
	input wire edfa_pkg::edfa_event_t event_data
);
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);
	// Tracks the off-event enable, so a masked off event is not required.
	logic off_en_reg;
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			off_en_reg <= 1'b1;
		end else if (psel && penable && pwrite && paddr == 12'h000) begin
			off_en_reg <= pwdata[1];
		end
	end
	sequence s_rise;
		$rose(alarm);
	endsequence
	sequence s_on_evt;
		event_valid && event_data.on;
	endsequence
	property p_move;
		$changed(alarm) |-> $past(meas_valid);
	endproperty
	a_move: assert property (p_move) else $error("alarm moved without update");
	property p_lat;
		s_rise |-> ##35 s_on_evt;
	endproperty
	a_lat: assert property (p_lat) else $error("on event missing");
	property p_off;
		$fell(alarm) && off_en_reg |-> ##35 (event_valid && !event_data.on);
	endproperty
	a_off: assert property (p_off) else $error("off event missing");
	property p_src;
		event_valid |-> $past(meas_valid, 36);
	endproperty
	a_src: assert property (p_src) else $error("event without cause");
	property p_hold;
		!event_valid |-> $stable(event_data);
	endproperty
	a_hold: assert property (p_hold) else $error("event data moved");
	property p_volt;
		s_rise |-> $past(meas.u0_meas) > 16'h0064 || $past(meas.u0_calc) > 16'h0064;
	endproperty
	a_volt: assert property (p_volt) else $error("alarm without voltage");
	property p_cur;
		s_rise |-> $past(meas.cur_coarse) > 16'h000A || $past(meas.cur_sens) > 16'h000A
			|| $past(meas.cur_calc) > 16'h000A;
	endproperty
	a_cur: assert property (p_cur) else $error("alarm without current");
	property p_err;
		psel && !penable && paddr == 12'h100 |=> pslverr;
	endproperty
	a_err: assert property (p_err) else $error("no error on hole");
endmodule : edfa_top_chk
bind edfa_top edfa_top_chk edfa_top_chk_i (.sys_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .pslverr,
	.meas, .meas_valid, .alarm, .event_valid, .event_data);

// ---- verification/edfa_bench.sv ----
// Self-checking bench of the alarm block.
`timescale 1ns/1ps
module edfa_bench;
	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	edfa_pkg::edfa_meas_t smp = '0;
	edfa_pkg::edfa_meas_t meas;
	logic meas_valid;
	logic [2:0] setting_group = 3'h0;
	logic symf = 1'b0;
	logic alarm;
	logic event_valid;
	edfa_pkg::edfa_event_t event_data;
	edfa_pkg::edfa_event_t ev;
	logic [31:0] rdat;
	logic rerr;
	logic [31:0] t0;
	logic [11:0] g;
	logic [15:0] dflt [9] = '{16'h04B0, 16'h07D0, 16'h0011, 16'h04B0, 16'h07D0, 16'h0370, 16'h0000, 16'hFC7C, 16'h81C2};
	logic [11:0] angs [7] = '{12'hA8C, 12'h708, 12'h000, 12'hA8C, 12'h71C, 12'hDFC, 12'h71B};
	int num_errors = 0;
	int cmp_count = 0;
	int seed = 32'h0BD9;
	int np = 0;
	int evn = 0;
	int n0;
	int i;
	always #5 sys_clk = ~sys_clk;
	edfa_top #(.MS_CYCLES(10)) edfa_top_i (.sys_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .meas, .meas_valid, .setting_group, .fault_phases(3'h5), .sym_fault(symf), .alarm,
		.event_valid, .event_data);
	edfa_front #(.PERIOD(edfa_pkg::MEAS_PERIOD_MS * 10)) edfa_front_i (.sys_clk, .rst_b, .sample_in(smp), .meas,
		.meas_valid);
	always @(posedge sys_clk) begin
		np <= np + 32'(meas_valid === 1'b1);
		if (event_valid === 1'b1) begin
			ev <= event_data;
			evn <= np;
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rd(input logic [11:0] ad, input logic [31:0] exp);
		apb(1'b0, ad, 32'h0);
		chk(rdat, exp);
	endtask : rd
	// Waits for the update that carries the new sample, then for its record.
	task automatic upd(input logic [15:0] c, input logic [15:0] s, input logic [15:0] u, input logic [11:0] a);
		@(posedge sys_clk);
		smp <= {c, s, 16'h0000, u, 16'h0000, a};
		repeat (2) @(posedge sys_clk);
		while (meas_valid !== 1'b1) @(posedge sys_clk);
		repeat (40) @(posedge sys_clk);
	endtask : upd
	task automatic al(input logic [15:0] c, input logic [15:0] s, input logic [11:0] a, input logic e);
		upd(c, s, 16'h0BB8, a);
		chk({31'h0, alarm}, {31'h0, e});
	endtask : al
	task automatic complete_run();
		if (num_errors == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : complete_run
	// Whole run is under 4000 cycles; fifteen times that is a hang.
	initial begin
		#600000;
		num_errors++;
		complete_run();
	end
	initial begin
		repeat (6) @(posedge sys_clk);
		rst_b <= 1'b1;
		rd(12'h000, 32'h3);
		for (i = 0; i < 9; i++) begin
			rd(12'h200 + 12'(i * 4), {16'h0, dflt[i]});
		end
		apb(1'b0, 12'h100, 32'h0);
		chk({31'h0, rerr}, 32'h1);
		al(16'h07D0, 16'h0, 12'hA8C, 1'b1);
		chk({31'h0, ev.on}, 32'h1);
		t0 = ev.stamp;
		n0 = evn;
		rd(12'h008, 32'h1);
		rd(12'h01C, 32'h105);
		rd(12'h020, 32'h682);
		rd(12'h028, 32'hA8C);
		al(16'h0492, 16'h0, 12'h000, 1'b1);
		al(16'h048A, 16'h0, 12'h000, 1'b0);
		chk({31'h0, ev.on}, 32'h0);
		chk(ev.stamp - t0, 32'(edfa_pkg::MEAS_PERIOD_MS * (evn - n0)));
		upd(16'h07D0, 16'h0, 16'h0064, 12'hA8C);
		chk({31'h0, alarm}, 32'h0);
		al(16'h07D0, 16'h0, 12'h384, 1'b0);
		for (i = 0; i < 4; i++) begin
			apb(1'b1, 12'h208, 32'(17 + i));
			al(16'h07D0, 16'h0, angs[i], 1'b1);
			al(16'h0, 16'h0, 12'h000, 1'b0);
		end
		apb(1'b1, 12'h208, 32'h11);
		apb(1'b1, 12'h240, 32'hBB8);
		setting_group <= 3'h1;
		al(16'h07D0, 16'h0, 12'hA8C, 1'b0);
		setting_group <= 3'h0;
		al(16'h07D0, 16'h0, 12'hA8C, 1'b1);
		al(16'h0, 16'h0, 12'h000, 1'b0);
		apb(1'b1, 12'h208, 32'h111);
		al(16'h07D0, 16'h0, 12'hA8C, 1'b0);
		al(16'h0, 16'h07D0, 12'hA8C, 1'b1);
		al(16'h0, 16'h0, 12'h000, 1'b0);
		apb(1'b1, 12'h208, 32'h1011);
		al(16'h07D0, 16'h0, 12'hA8C, 1'b0);
		apb(1'b1, 12'h208, 32'h24);
		al(16'h07D0, 16'h0, 12'hA8C, 1'b0);
		symf <= 1'b1;
		al(16'h07D0, 16'h0, 12'hA8C, 1'b1);
		apb(1'b1, 12'h000, 32'h1);
		al(16'h0, 16'h0, 12'h000, 1'b0);
		chk({31'h0, ev.on}, 32'h1);
		apb(1'b1, 12'h208, 32'h11);
		for (i = 0; i < 23; i++) begin
			g = (i < 3) ? angs[i + 4] : 12'($unsigned($random(seed)) % 3600);
			al(16'h07D0, 16'h0, g, 1'(g >= 12'h71C && g <= 12'hDFC));
			al(16'h0, 16'h0, 12'h000, 1'b0);
		end
		apb(1'b0, 12'h014, 32'h0);
		chk({28'h0, rdat[3:0]}, 32'hC);
		apb(1'b1, 12'h000, 32'h7);
		rd(12'h008, 32'h0);
		complete_run();
	end
endmodule : edfa_bench
